/* File: src/frsp_pkg.sv */
// Purpose: shared constants for the flash row self-programming pair
// Assumes: 250 MHz clock, 16-bit register bus, 24-bit instruction words
// Notes: register addresses are byte addresses on the register bus
//
// How it works
// - row holds 32 words, 96 bytes
// - panel holds 128 rows
// - erase works one whole row
// - host reloads page at panel crossings
// - each panel has 32-word write latches
// - host fills latches ascending from aligned start
// - table write is single word, two cycles
// - one program cycle per row; latches alone inert
// - low pointer captures address bits 15..0
// - upper pointer captures address bits 23..16
// - software may write both pointers directly
// - write-only key, 0x55 then 0xAA
// - operation lasts 2 ms, processor stalled
// - go bit 15 launches, hardware clears it
// - erase setup: control, address, unlock, go
// - program setup: latches, control, unlock, go
// - control 0x4041 selects row erase
// - host keeps key writes back to back
// - host waits two idle slots after go
// - 32 low plus 32 high table writes
// - high store keeps low source byte only
`default_nettype none

package frsp_pkg;
   // register addresses
   localparam logic [15:0] ADDR_CTL = 16'h0760;
   localparam logic [15:0] ADDR_PTR_LO = 16'h0762;
   localparam logic [15:0] ADDR_PTR_UP = 16'h0764;
   localparam logic [15:0] ADDR_KEY = 16'h0766;
   // control fields
   localparam int GO_BIT = 15;
   localparam int PERMIT_BIT = 14;
   localparam int ERR_BIT = 13;
   localparam int OP_MSB = 6;
   localparam int OP_W = 7;
   localparam logic [6:0] OP_ERASE_ROW = 7'h41;
   localparam logic [6:0] OP_PROG_ROW = 7'h01;
   localparam logic [15:0] CTL_ERASE_ROW = 16'h4041;
   localparam logic [15:0] CTL_PROG_ROW = 16'h4001;
   localparam logic [15:0] CTL_GO_MASK = 16'h8000;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   // unlock keys
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   // array geometry
   localparam int ROW_WORDS = 32;
   localparam int ROW_BYTES = 96;
   localparam int PANEL_ROWS = 128;
   localparam int WORD_LSB = 1;
   localparam int LATCH_MSB = 5;
   localparam int PANEL_LSB = 13;
   localparam int PTR_UP_LSB = 16;
   localparam int PTR_UP_W = 8;
   localparam logic [23:0] ERASED_WORD = 24'hFFFFFF;
   // timing
   localparam int TBL_CYCLES = 2;
   localparam int CLK_PERIOD_NS = 4;
   localparam int OP_TIME_NS = 2000000;
   localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
   localparam int NOP_SLOTS = 2;
   // host request codes
   typedef enum logic [1:0] {
      REQ_ERASE,
      REQ_LOAD,
      REQ_PROG,
      REQ_READ
   } frsp_req_t;
endpackage // frsp_pkg

`default_nettype wire

/* File: src/frsp_if.sv */
// Purpose: processor-to-flash-controller register and table bus
// Assumes: one clock shared by both ends
// Notes: stall holds every strobe of the host end
`default_nettype none

interface frsp_if;
   // register access
   logic sfr_we;
   logic sfr_re;
   logic [15:0] sfr_addr;
   logic [15:0] sfr_wdata;
   logic [15:0] sfr_rdata;
   // table stores
   logic tbl_we;
   logic tbl_hi;
   logic [23:0] tbl_addr;
   logic [15:0] tbl_wdata;
   // processor hold
   logic stall;

   modport dev (
      input sfr_we, sfr_re, sfr_addr, sfr_wdata, tbl_we, tbl_hi, tbl_addr,
      input tbl_wdata,
      output sfr_rdata, stall
   );
   modport host (
      output sfr_we, sfr_re, sfr_addr, sfr_wdata, tbl_we, tbl_hi, tbl_addr,
      output tbl_wdata,
      input sfr_rdata, stall
   );
endinterface // frsp_if

`default_nettype wire

/* File: src/frsp_dev.sv */
// Purpose: flash controller end: latches, pointers, unlock, erase/program
// Assumes: host holds strobes while stall is high
// Notes: flash array is modelled as a plain word memory
`default_nettype none

module frsp_dev #(
   parameter int PANELS = 1,
   parameter int OP_CYCLES = frsp_pkg::OP_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // processor side
   frsp_if.dev bus,
   // array inspection
   input wire logic [23:0] flash_raddr,
   output logic [23:0] flash_rdata,
   // status
   output logic busy
);
   localparam int WORDS = PANELS * frsp_pkg::PANEL_ROWS * frsp_pkg::ROW_WORDS;
   localparam int LATCHES = PANELS * frsp_pkg::ROW_WORDS;
   localparam int CW = $clog2(OP_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(OP_CYCLES - 1);
   localparam logic [CW-1:0] CNT_ROW = CW'(frsp_pkg::ROW_WORDS);
   localparam logic [1:0] HOLD_LOAD = 2'(frsp_pkg::TBL_CYCLES - 1);

   typedef enum logic [1:0] {
      key_idle,
      key_half,
      key_armed
   } frsp_key_t;

   // word index into the array
   function automatic int word_idx(input logic [23:0] a);
      return int'(a >> frsp_pkg::WORD_LSB) % WORDS;
   endfunction

   // first word of the row holding a
   function automatic int row_base(input logic [23:0] a);
      int w;
      w = word_idx(a);
      return w - (w % frsp_pkg::ROW_WORDS);
   endfunction

   // latch slot: panel set plus position in the row
   function automatic int latch_idx(input logic [23:0] a);
      int p;
      p = int'(a >> frsp_pkg::PANEL_LSB) % PANELS;
      return p * frsp_pkg::ROW_WORDS
         + int'(a[frsp_pkg::LATCH_MSB:frsp_pkg::WORD_LSB]);
   endfunction

   function automatic logic op_ok(input logic [6:0] op);
      return op == frsp_pkg::OP_ERASE_ROW || op == frsp_pkg::OP_PROG_ROW;
   endfunction

   // storage
   logic [23:0] flash_mem [WORDS];
   logic [23:0] latch_mem [LATCHES];

   // registers
   logic permit_r;
   logic [6:0] op_r;
   logic go_r;
   logic [15:0] ptr_lo_r;
   logic [7:0] ptr_up_r;
   frsp_key_t key_r;
   logic [CW-1:0] cnt_r;
   logic erase_r;
   logic [23:0] tgt_r;
   logic [1:0] hold_r;
   logic [15:0] rdata_r;
   logic [23:0] flash_rdata_r;

   // decoded strobes
   logic stall;
   logic take_sfr;
   logic take_tbl;
   logic wr_ctl;
   logic wr_lo;
   logic wr_up;
   logic wr_key;
   logic launch;
   logic [23:0] ptr;

   assign stall = go_r || (hold_r != 2'h0);
   assign take_sfr = bus.sfr_we && !stall;
   assign take_tbl = bus.tbl_we && !stall;
   assign wr_ctl = take_sfr && bus.sfr_addr == frsp_pkg::ADDR_CTL;
   assign wr_lo = take_sfr && bus.sfr_addr == frsp_pkg::ADDR_PTR_LO;
   assign wr_up = take_sfr && bus.sfr_addr == frsp_pkg::ADDR_PTR_UP;
   assign wr_key = take_sfr && bus.sfr_addr == frsp_pkg::ADDR_KEY;
   assign ptr = {ptr_up_r, ptr_lo_r};

   // go only straight after unlock, with permit and a known operation
   assign launch = wr_ctl && bus.sfr_wdata[frsp_pkg::GO_BIT]
      && bus.sfr_wdata[frsp_pkg::PERMIT_BIT] && key_r == key_armed
      && op_ok(bus.sfr_wdata[frsp_pkg::OP_MSB:0]);

   assign bus.stall = stall;
   assign bus.sfr_rdata = rdata_r;
   assign busy = go_r;
   assign flash_rdata = flash_rdata_r;

   // control fields
   always_ff @(posedge clk) begin
      if (rst) begin
         permit_r <= frsp_pkg::CTL_RESET[frsp_pkg::PERMIT_BIT];
         op_r <= frsp_pkg::CTL_RESET[frsp_pkg::OP_MSB:0];
      end else if (wr_ctl) begin
         permit_r <= bus.sfr_wdata[frsp_pkg::PERMIT_BIT];
         op_r <= bus.sfr_wdata[frsp_pkg::OP_MSB:0];
      end
   end

   // go bit: set by launch, cleared by hardware at the end
   always_ff @(posedge clk) begin
      if (rst) begin
         go_r <= 1'b0;
      end else if (launch) begin
         go_r <= 1'b1;
      end else if (go_r && cnt_r == CNT_LAST) begin
         go_r <= 1'b0;
      end
   end

   // row pointers: table stores capture, direct writes override
   always_ff @(posedge clk) begin
      if (rst) begin
         ptr_lo_r <= 16'h0000;
         ptr_up_r <= 8'h00;
      end else begin
         if (take_tbl) begin
            ptr_lo_r <= bus.tbl_addr[frsp_pkg::PTR_UP_LSB-1:0];
            ptr_up_r <= bus.tbl_addr[23:frsp_pkg::PTR_UP_LSB];
         end
         if (wr_lo) begin
            ptr_lo_r <= bus.sfr_wdata;
         end
         if (wr_up) begin
            ptr_up_r <= bus.sfr_wdata[frsp_pkg::PTR_UP_W-1:0];
         end
      end
   end

   // unlock sequence; any other write disarms it
   always_ff @(posedge clk) begin
      if (rst) begin
         key_r <= key_idle;
      end else if (wr_key) begin
         case (key_r)
            key_idle: begin
               key_r <= (bus.sfr_wdata[7:0] == frsp_pkg::KEY_FIRST)
                  ? key_half : key_idle;
            end
            key_half: begin
               if (bus.sfr_wdata[7:0] == frsp_pkg::KEY_SECOND) begin
                  key_r <= key_armed;
               end else if (bus.sfr_wdata[7:0] == frsp_pkg::KEY_FIRST) begin
                  key_r <= key_half;
               end else begin
                  key_r <= key_idle;
               end
            end
            default: begin
               key_r <= (bus.sfr_wdata[7:0] == frsp_pkg::KEY_FIRST)
                  ? key_half : key_idle;
            end
         endcase
      end else if (take_sfr || take_tbl) begin
         key_r <= key_idle;
      end
   end

   // table store occupies a second cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_r <= 2'h0;
      end else if (take_tbl) begin
         hold_r <= HOLD_LOAD;
      end else if (hold_r != 2'h0) begin
         hold_r <= hold_r - 2'h1;
      end
   end

   // latch loading touches only the latches
   always_ff @(posedge clk) begin
      if (take_tbl) begin
         if (bus.tbl_hi) begin
            latch_mem[latch_idx(bus.tbl_addr)][23:16] <= bus.tbl_wdata[7:0];
         end else begin
            latch_mem[latch_idx(bus.tbl_addr)][15:0] <= bus.tbl_wdata;
         end
      end
   end

   // operation target and kind, frozen at launch
   always_ff @(posedge clk) begin
      if (rst) begin
         erase_r <= 1'b0;
         tgt_r <= 24'h000000;
      end else if (launch) begin
         erase_r <= bus.sfr_wdata[frsp_pkg::OP_MSB:0] == frsp_pkg::OP_ERASE_ROW;
         tgt_r <= ptr;
      end
   end

   // duration counter
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (launch) begin
         cnt_r <= '0;
      end else if (go_r) begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   // row update, one word per cycle at the start of the operation
   always_ff @(posedge clk) begin
      if (go_r && cnt_r < CNT_ROW) begin
         if (erase_r) begin
            flash_mem[row_base(tgt_r) + int'(cnt_r)] <= frsp_pkg::ERASED_WORD;
         end else begin
            flash_mem[row_base(tgt_r) + int'(cnt_r)] <=
               latch_mem[latch_idx(tgt_r) - int'(tgt_r[frsp_pkg::LATCH_MSB:
                  frsp_pkg::WORD_LSB]) + int'(cnt_r)];
         end
      end
   end

   // register read back; key reads as zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= 16'h0000;
      end else if (bus.sfr_re && !stall) begin
         case (bus.sfr_addr)
            frsp_pkg::ADDR_CTL: begin
               rdata_r <= {go_r, permit_r, 7'h00, op_r};
            end
            frsp_pkg::ADDR_PTR_LO: begin
               rdata_r <= ptr_lo_r;
            end
            frsp_pkg::ADDR_PTR_UP: begin
               rdata_r <= {8'h00, ptr_up_r};
            end
            default: begin
               rdata_r <= 16'h0000;
            end
         endcase
      end
   end

   // array inspection port
   always_ff @(posedge clk) begin
      if (rst) begin
         flash_rdata_r <= 24'h000000;
      end else begin
         flash_rdata_r <= flash_mem[word_idx(flash_raddr)];
      end
   end
endmodule // frsp_dev

`default_nettype wire

/* File: src/frsp_host.sv */
// Purpose: processor end: turns requests into register and table cycles
// Assumes: device stall holds every step
// Notes: one request at a time
`default_nettype none

module frsp_host (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // device side
   frsp_if.host bus,
   // requests
   input wire logic req_valid,
   output logic req_ready,
   input wire frsp_pkg::frsp_req_t req_op,
   input wire logic [23:0] req_addr,
   input wire logic [23:0] req_data,
   // answers
   output logic done,
   output logic [15:0] rsp_data
);
   typedef enum logic [3:0] {
      h_idle, h_ctl, h_adru, h_adrl, h_key1, h_key2, h_go,
      h_nop1, h_nop2, h_tlo, h_thi, h_read, h_rwait
   } frsp_hst_t;

   frsp_hst_t st_r;
   frsp_pkg::frsp_req_t op_r;
   logic [23:0] addr_r;
   logic [23:0] data_r;
   logic done_r;
   logic [15:0] rsp_r;
   logic [15:0] ctl_val;
   logic go_on;

   assign req_ready = st_r == h_idle;
   assign done = done_r;
   assign rsp_data = rsp_r;
   assign go_on = !bus.stall;
   assign ctl_val = (op_r == frsp_pkg::REQ_ERASE)
      ? frsp_pkg::CTL_ERASE_ROW : frsp_pkg::CTL_PROG_ROW;

   // bus drive from the step
   always_comb begin
      bus.sfr_we = 1'b0;
      bus.sfr_re = 1'b0;
      bus.sfr_addr = frsp_pkg::ADDR_CTL;
      bus.sfr_wdata = 16'h0000;
      bus.tbl_we = 1'b0;
      bus.tbl_hi = 1'b0;
      bus.tbl_addr = addr_r;
      bus.tbl_wdata = data_r[15:0];
      case (st_r)
         h_ctl: begin
            bus.sfr_we = 1'b1;
            bus.sfr_wdata = ctl_val;
         end
         h_adru: begin
            bus.sfr_we = 1'b1;
            bus.sfr_addr = frsp_pkg::ADDR_PTR_UP;
            bus.sfr_wdata = {8'h00, addr_r[23:16]};
         end
         h_adrl: begin
            bus.sfr_we = 1'b1;
            bus.sfr_addr = frsp_pkg::ADDR_PTR_LO;
            bus.sfr_wdata = addr_r[15:0];
         end
         h_key1: begin
            bus.sfr_we = 1'b1;
            bus.sfr_addr = frsp_pkg::ADDR_KEY;
            bus.sfr_wdata = {8'h00, frsp_pkg::KEY_FIRST};
         end
         h_key2: begin
            bus.sfr_we = 1'b1;
            bus.sfr_addr = frsp_pkg::ADDR_KEY;
            bus.sfr_wdata = {8'h00, frsp_pkg::KEY_SECOND};
         end
         h_go: begin
            bus.sfr_we = 1'b1;
            bus.sfr_wdata = ctl_val | frsp_pkg::CTL_GO_MASK;
         end
         h_tlo: begin
            bus.tbl_we = 1'b1;
         end
         h_thi: begin
            bus.tbl_we = 1'b1;
            bus.tbl_hi = 1'b1;
            bus.tbl_wdata = {8'h00, data_r[23:16]};
         end
         h_read: begin
            bus.sfr_re = 1'b1;
            bus.sfr_addr = addr_r[15:0];
         end
         default: begin
            bus.sfr_we = 1'b0;
         end
      endcase
   end

   // sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= h_idle;
      end else if (st_r == h_idle) begin
         if (req_valid) begin
            case (req_op)
               frsp_pkg::REQ_LOAD: st_r <= h_tlo;
               frsp_pkg::REQ_READ: st_r <= h_read;
               default: st_r <= h_ctl;
            endcase
         end
      end else if (go_on) begin
         case (st_r)
            h_ctl: st_r <= (op_r == frsp_pkg::REQ_ERASE) ? h_adru : h_key1;
            h_adru: st_r <= h_adrl;
            h_adrl: st_r <= h_key1;
            h_key1: st_r <= h_key2;
            h_key2: st_r <= h_go;
            h_go: st_r <= h_nop1;
            h_nop1: st_r <= h_nop2;
            h_tlo: st_r <= h_thi;
            h_read: st_r <= h_rwait;
            default: st_r <= h_idle;
         endcase
      end
   end

   // request capture
   always_ff @(posedge clk) begin
      if (rst) begin
         op_r <= frsp_pkg::REQ_ERASE;
         addr_r <= 24'h000000;
         data_r <= 24'h000000;
      end else if (st_r == h_idle && req_valid) begin
         op_r <= req_op;
         addr_r <= req_addr;
         data_r <= req_data;
      end
   end

   // completion and read data
   always_ff @(posedge clk) begin
      if (rst) begin
         done_r <= 1'b0;
         rsp_r <= 16'h0000;
      end else begin
         done_r <= go_on
            && (st_r == h_nop2 || st_r == h_thi || st_r == h_rwait);
         if (st_r == h_rwait) begin
            rsp_r <= bus.sfr_rdata;
         end
      end
   end
endmodule // frsp_host

`default_nettype wire

/* File: test/frsp_sva.sv */
// Purpose: bus checker for the flash row self-programming pair
// Assumes: one clock, synchronous active-high reset
// Notes: watches the interface between host end and device end
`default_nettype none

module frsp_sva #(
   parameter int OP_CYCLES = frsp_pkg::OP_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register bus
   input wire logic sfr_we,
   input wire logic sfr_re,
   input wire logic [15:0] sfr_addr,
   input wire logic [15:0] sfr_wdata,
   input wire logic [15:0] sfr_rdata,
   // table stores and hold
   input wire logic tbl_we,
   input wire logic [23:0] tbl_addr,
   input wire logic stall,
   input wire logic busy
);
   logic k1_r, k2_r, wr_t, key_w, ctl_w, ctl_go, go_ok;
   logic [15:0] plo_r;
   int cnt_r;

   assign wr_t = (sfr_we | tbl_we) & !stall;
   assign key_w = sfr_we & (sfr_addr == frsp_pkg::ADDR_KEY);
   assign ctl_w = sfr_we & !stall & (sfr_addr == frsp_pkg::ADDR_CTL);
   assign ctl_go = ctl_w & sfr_wdata[frsp_pkg::GO_BIT];
   assign go_ok = k2_r & sfr_wdata[frsp_pkg::PERMIT_BIT]
      & ((sfr_wdata[6:0] == frsp_pkg::OP_ERASE_ROW)
      | (sfr_wdata[6:0] == frsp_pkg::OP_PROG_ROW));

   // unlock key tracking
   always_ff @(posedge clk) begin
      if (rst) begin
         k1_r <= 1'h0;
         k2_r <= 1'h0;
      end else if (wr_t) begin
         k1_r <= key_w & (sfr_wdata[7:0] == frsp_pkg::KEY_FIRST);
         k2_r <= key_w & k1_r & (sfr_wdata[7:0] == frsp_pkg::KEY_SECOND);
      end
   end

   // shadow of the low row pointer
   always_ff @(posedge clk) begin
      if (rst) begin
         plo_r <= 16'h0000;
      end else if (sfr_we & !stall & (sfr_addr == frsp_pkg::ADDR_PTR_LO)) begin
         plo_r <= sfr_wdata;
      end else if (tbl_we & !stall) begin
         plo_r <= tbl_addr[15:0];
      end
   end

   // busy length counter
   always_ff @(posedge clk) begin
      if (rst | !busy) begin
         cnt_r <= 0;
      end else begin
         cnt_r <= cnt_r + 1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_TBL_HOLD: assert property (tbl_we && !stall |=> stall ##1 !stall)
      else $error("table store hold is not one cycle");
   AST_LAUNCH: assert property (ctl_go && go_ok |=> busy && stall)
      else $error("armed go write did not launch");
   AST_NO_LAUNCH: assert property (ctl_w && !(ctl_go && go_ok)
      |=> !busy)
      else $error("go write launched without unlock or permit");
   AST_OP_LEN: assert property ($fell(busy) |-> cnt_r == OP_CYCLES)
      else $error("operation length wrong");
   AST_BUSY_STALL: assert property (busy |-> stall)
      else $error("processor not held during operation");
   AST_RD_HOLD: assert property (!(sfr_re && !stall)
      |=> $stable(sfr_rdata))
      else $error("read data changed without a read");
   AST_KEY_RD: assert property (sfr_re && !stall
      && sfr_addr == frsp_pkg::ADDR_KEY |=> sfr_rdata == 16'h0000)
      else $error("key register read not zero");
   AST_PTR_RD: assert property (sfr_re && !stall
      && sfr_addr == frsp_pkg::ADDR_PTR_LO |=> sfr_rdata == $past(plo_r))
      else $error("low pointer read wrong");
   AST_RESET: assert property (@(posedge clk) disable iff (1'h0)
      rst |=> !stall && !busy)
      else $error("hold active after reset");
endmodule // frsp_sva

`default_nettype wire

/* File: test/frsp_bench.sv */
// Purpose: self-checking bench for the flash row self-programming pair
// Assumes: short operation length of 40 cycles
// Notes: second device end is driven directly to break the unlock rules
`default_nettype none

module frsp_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OPN = 40;
   localparam logic [23:0] ROW_A = 24'h000040;
   localparam logic [23:0] ROW_C = 24'h000100;
   logic clk, rst, req_valid, req_ready, done, busy, busy2;
   frsp_pkg::frsp_req_t req_op;
   logic [23:0] req_addr, req_data, fra, frd, fra2, frd2;
   logic [15:0] rsp_data;
   int num_errors, checked, n;
   frsp_if bus_if();
   frsp_if bus2_if();

   frsp_dev #(.OP_CYCLES(OPN)) frsp_dev_i (.clk(clk), .rst(rst),
      .bus(bus_if.dev), .flash_raddr(fra), .flash_rdata(frd), .busy(busy));
   frsp_dev #(.OP_CYCLES(OPN)) frsp_dev_i2 (.clk(clk), .rst(rst),
      .bus(bus2_if.dev), .flash_raddr(fra2), .flash_rdata(frd2),
      .busy(busy2));
   frsp_host frsp_host_i (.clk(clk), .rst(rst), .bus(bus_if.host),
      .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
      .req_addr(req_addr), .req_data(req_data), .done(done),
      .rsp_data(rsp_data));
   frsp_sva #(.OP_CYCLES(OPN)) frsp_sva_i (.clk(clk), .rst(rst),
      .sfr_we(bus_if.sfr_we), .sfr_re(bus_if.sfr_re),
      .sfr_addr(bus_if.sfr_addr), .sfr_wdata(bus_if.sfr_wdata),
      .sfr_rdata(bus_if.sfr_rdata), .tbl_we(bus_if.tbl_we),
      .tbl_addr(bus_if.tbl_addr), .stall(bus_if.stall), .busy(busy));

   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp(input string what, input logic [23:0] exp,
      input logic [23:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic hang();
      num_errors++;
      $display("ERROR wait expected done seen timeout");
      finish_test();
   endtask

   task automatic hreq(input frsp_pkg::frsp_req_t op,
      input logic [23:0] a, input logic [23:0] d);
      for (n = 0; req_ready !== 1'h1; n++) begin
         if (n > 200) hang();
         @(negedge clk);
      end
      req_op = op;
      req_addr = a;
      req_data = d;
      req_valid = 1'h1;
      @(negedge clk);
      req_valid = 1'h0;
      for (n = 0; done !== 1'h1; n++) begin
         if (n > OPN + 200) hang();
         @(negedge clk);
      end
   endtask

   task automatic fchk(input bit two, input logic [23:0] a,
      input logic [23:0] e);
      fra = a;
      fra2 = a;
      @(negedge clk);
      cmp("flash word", e, two ? frd2 : frd);
   endtask

   task automatic drv2(input logic we, input logic re, input logic tb,
      input logic [15:0] a, input logic [15:0] d);
      bus2_if.sfr_we = we;
      bus2_if.sfr_re = re;
      bus2_if.tbl_we = tb;
      bus2_if.sfr_addr = a;
      bus2_if.sfr_wdata = d;
      bus2_if.tbl_wdata = d;
      @(negedge clk);
   endtask

   task automatic w2(input logic [15:0] a, input logic [15:0] d);
      drv2(1'h1, 1'h0, 1'h0, a, d);
   endtask

   task automatic r2(input logic [15:0] a);
      drv2(1'h0, 1'h1, 1'h0, a, 16'h0000);
   endtask

   task automatic t2(input logic [23:0] a, input logic hi,
      input logic [15:0] d);
      bus2_if.tbl_addr = a;
      bus2_if.tbl_hi = hi;
      drv2(1'h0, 1'h0, 1'h1, 16'h0000, d);
      cmp("table hold", 24'h1, 24'(bus2_if.stall));
      drv2(1'h0, 1'h0, 1'h0, 16'h0000, 16'h0000);
   endtask

   task automatic run2();
      bus2_if.sfr_we = 1'h0;
      for (n = 0; busy2 === 1'h1; n++) begin
         if (n > OPN + 10) hang();
         @(negedge clk);
      end
   endtask

   task automatic unlock2();
      w2(frsp_pkg::ADDR_KEY, 16'h0055);
      w2(frsp_pkg::ADDR_KEY, 16'h00AA);
   endtask

   task automatic test_reset();
      cmp("stall", 24'h0, 24'(bus_if.stall));
      cmp("busy", 24'h0, 24'({busy, busy2}));
      cmp("ready", 24'h1, 24'(req_ready));
      cmp("done", 24'h0, 24'(done));
      $display("test_reset finished");
   endtask

   task automatic test_host_row();
      hreq(frsp_pkg::REQ_ERASE, ROW_A, 24'h0);
      hreq(frsp_pkg::REQ_ERASE, ROW_C, 24'h0);
      fchk(1'b0, ROW_A + 24'd62, frsp_pkg::ERASED_WORD);
      for (int i = 0; i < 32; i++) begin
         hreq(frsp_pkg::REQ_LOAD, ROW_A + 24'(2 * i),
            {8'(i) ^ 8'hC3, 16'h5A00 + 16'(i)});
      end
      fchk(1'b0, ROW_A, frsp_pkg::ERASED_WORD);
      hreq(frsp_pkg::REQ_PROG, ROW_A, 24'h0);
      for (int i = 0; i < 32; i++) begin
         fchk(1'b0, ROW_A + 24'(2 * i),
            {8'(i) ^ 8'hC3, 16'h5A00 + 16'(i)});
      end
      fchk(1'b0, ROW_C, frsp_pkg::ERASED_WORD);
      hreq(frsp_pkg::REQ_READ, 24'(frsp_pkg::ADDR_CTL), 24'h0);
      cmp("control", 24'h004001, 24'(rsp_data));
      hreq(frsp_pkg::REQ_READ, 24'(frsp_pkg::ADDR_KEY), 24'h0);
      cmp("key read", 24'h0, 24'(rsp_data));
      hreq(frsp_pkg::REQ_READ, 24'(frsp_pkg::ADDR_PTR_LO), 24'h0);
      cmp("host pointer", ROW_A + 24'd62, 24'(rsp_data));
      $display("test_host_row finished");
   endtask

   task automatic test_unlock();
      w2(frsp_pkg::ADDR_PTR_UP, 16'h0000);
      w2(frsp_pkg::ADDR_PTR_LO, ROW_C[15:0]);
      for (int c = 0; c < 3; c++) begin
         if (c != 1) w2(frsp_pkg::ADDR_KEY, 16'h0055);
         w2(frsp_pkg::ADDR_KEY, 16'h00AA);
         if (c == 0) w2(frsp_pkg::ADDR_PTR_LO, ROW_C[15:0]);
         w2(frsp_pkg::ADDR_CTL, (c == 2) ? 16'h8041 : 16'hC041);
         cmp("locked go", 24'h0, 24'(busy2));
      end
      w2(frsp_pkg::ADDR_KEY, 16'h0055);
      unlock2();
      w2(frsp_pkg::ADDR_CTL, 16'hC041);
      cmp("launch", 24'h1, 24'(busy2));
      run2();
      cmp("op cycles", 24'(OPN), 24'(n));
      r2(frsp_pkg::ADDR_CTL);
      cmp("control", 24'h004041, 24'(bus2_if.sfr_rdata));
      r2(frsp_pkg::ADDR_PTR_LO);
      cmp("pointer", 24'(ROW_C[15:0]), 24'(bus2_if.sfr_rdata));
      fchk(1'b1, ROW_C + 24'd62, frsp_pkg::ERASED_WORD);
      $display("test_unlock finished");
   endtask

   task automatic test_high_byte();
      t2(24'h050040, 1'h0, 16'h0000);
      r2(frsp_pkg::ADDR_PTR_UP);
      cmp("upper pointer", 24'h05, 24'(bus2_if.sfr_rdata[7:0]));
      r2(frsp_pkg::ADDR_PTR_LO);
      cmp("low pointer", 24'h0040, 24'(bus2_if.sfr_rdata));
      t2(ROW_C, 1'h0, 16'h1234);
      t2(ROW_C, 1'h1, 16'hEE77);
      unlock2();
      w2(frsp_pkg::ADDR_CTL, frsp_pkg::CTL_PROG_ROW | frsp_pkg::CTL_GO_MASK);
      run2();
      fchk(1'b1, ROW_C, 24'h771234);
      $display("test_high_byte finished");
   endtask

   initial begin
      num_errors = 0;
      checked = 0;
      rst = 1'h1;
      req_valid = 1'h0;
      req_op = frsp_pkg::REQ_READ;
      req_addr = 24'h0;
      req_data = 24'h0;
      fra = 24'h0;
      fra2 = 24'h0;
      bus2_if.tbl_addr = 24'h0;
      bus2_if.tbl_hi = 1'h0;
      drv2(1'h0, 1'h0, 1'h0, 16'h0000, 16'h0000);
      @(negedge clk);
      rst = 1'h0;
      test_reset();
      test_host_row();
      test_unlock();
      test_high_byte();
      finish_test();
   end
endmodule // frsp_bench

`default_nettype wire
